// ==== shared/dpss_pkg.sv ====
/*
  Constants, register map and carrier types for the profile hot swap
  sequencer. Assumes a 250 MHz pclk and an APB host with 32-bit data.
*/
package dpss_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int SWITCH_TIME_NS = 50000;
  localparam int SWITCH_CYCLES = SWITCH_TIME_NS * CLK_MHZ / 1000;
  localparam int STAGE_CYCLES = 16;
  // Sizes
  localparam int MAX_PROFILES = 6;
  localparam int N_CH = 4;
  localparam int N_TAPS = 4;
  // Limits: rate in ksps, bandwidth in 100 kHz units
  localparam logic [15:0] MAX_RATE_KSPS = 16'hF000;
  localparam logic [9:0] MIN_BW_UNITS = 10'h00A;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] NEXT_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] COUNT_OFF = 8'h0C;
  localparam logic [7:0] FIXED_OFF = 8'h10;
  localparam logic [7:0] TAP_SEL_OFF = 8'h14;
  localparam logic [7:0] TAP_DATA_OFF = 8'h18;
  localparam logic [7:0] PROF_BASE_OFF = 8'h20;
  // Control bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HOP_BIT = 1;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_CLR_BIT = 3;
  // Reset values
  localparam logic [2:0] COUNT_RST = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Channel state codes seen on ch_state
  localparam logic [1:0] CH_STANDBY = 2'h0;
  localparam logic [1:0] CH_CALIBRATED = 2'h1;
  localparam logic [1:0] CH_PRIMED = 2'h2;
  localparam logic [1:0] CH_ACTIVE = 2'h3;
  // One profile descriptor, one register word
  typedef struct packed {
    logic [2:0] rsv;
    logic [1:0] duplex;
    logic lvds;
    logic [9:0] bw;
    logic [15:0] rate;
  } dpss_profile_s;
  // Settings that a switch never touches
  typedef struct packed {
    logic [2:0] rsv;
    logic interleave;
    logic [3:0] conv_code;
    logic [7:0] tia_code;
    logic [7:0] synth_code;
    logic [7:0] lo_code;
  } dpss_fixed_s;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_STAGE,
    SEQ_SWITCH
  } dpss_seq_e;
endpackage

// ==== hw/dpss_top.sv ====
/*
  Profile hot swap sequencer: APB register file, profile table,
  staging of the next profile and filter taps, and the timed switch.
  Assumes ch_state and APB come from logic on pclk; the enable pins
  are asynchronous and are synchronised here.
*/
module dpss_top #(
  parameter int SWITCH_CYC = dpss_pkg::SWITCH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dpss_pkg::N_CH-1:0][1:0] ch_state,
  input wire logic [1:0] tx_enable_pin,
  input wire logic [1:0] rx_enable_pin,
  output logic [1:0] tx_enable_out,
  output logic [1:0] rx_enable_out,
  output dpss_pkg::dpss_profile_s active_cfg,
  output logic [2:0] active_index,
  output logic [15:0] link_rate,
  output dpss_pkg::dpss_fixed_s fixed_cfg,
  output logic [dpss_pkg::N_TAPS-1:0][15:0] rx_taps,
  output logic [dpss_pkg::N_TAPS-1:0][15:0] tx_taps,
  output logic switch_busy,
  output logic stage_busy,
  output logic hot_swap_mode,
  output logic hop_mode
);
  import dpss_pkg::*;

  dpss_profile_s prof_reg [MAX_PROFILES]; // Profile table
  dpss_profile_s act_reg; // Profile in use
  dpss_fixed_s fixed_reg; // Switch-invariant settings
  dpss_seq_e seq_reg; // Sequencer state
  logic [2:0] count_reg; // Profiles configured
  logic [2:0] next_reg; // Staged index
  logic [2:0] act_idx_reg; // Active index
  logic next_vld_reg; // A profile is staged
  logic en_reg; // Hot swap mode
  logic hop_reg; // Hopping mode
  logic err_reg; // Sticky refusal flag
  logic [15:0] link_reg; // Sample link rate
  logic [3:0] tap_sel_reg; // Tap pointer
  logic [N_TAPS-1:0][15:0] rx_stg_reg; // Staged rx taps
  logic [N_TAPS-1:0][15:0] tx_stg_reg; // Staged tx taps
  logic taps_vld_reg; // Taps are staged
  logic [N_TAPS-1:0][15:0] rx_act_reg; // Rx taps in use
  logic [N_TAPS-1:0][15:0] tx_act_reg; // Tx taps in use
  logic [15:0] timer_reg; // Sequencer countdown
  logic [1:0] tx_s1_reg, tx_s2_reg; // Tx pin synchroniser
  logic [1:0] rx_s1_reg, rx_s2_reg; // Rx pin synchroniser
  logic [1:0] tx_out_reg, rx_out_reg; // Gated enables

  logic wr, rd; // Write strobe in access phase, read in setup and access
  logic hit_prof; // Address lands in table
  logic [2:0] prof_idx; // Table word index
  logic set_ok; // Table passes checks
  logic go_ok; // Switch may start
  logic all_primed; // No channel active
  logic go_req, stage_req; // Decoded commands
  logic go_bad, stage_bad, en_bad; // Refusals
  logic [2:0] main_idx; // Top configured index
  dpss_profile_s nxt; // Staged descriptor

  // Zero wait state slave
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign hit_prof = (paddr >= PROF_BASE_OFF) &&
    (paddr < PROF_BASE_OFF + 8'h18) && (paddr[1:0] == 2'b00);
  assign prof_idx = 3'((paddr - PROF_BASE_OFF) >> 2);
  assign main_idx = count_reg - 3'h1;
  assign nxt = prof_reg[next_reg];

  // Table check: main is highest, all wideband and differential
  always_comb begin
    set_ok = (count_reg >= 3'h2) &&
      (count_reg <= 3'(MAX_PROFILES));
    for (int i = 0; i < MAX_PROFILES; i++) begin
      if (3'(i) < count_reg) begin
        if (prof_reg[i].bw < MIN_BW_UNITS) begin
          set_ok = 1'b0;
        end
        if (prof_reg[i].rate > MAX_RATE_KSPS) begin
          set_ok = 1'b0;
        end
        if (!prof_reg[i].lvds) begin
          set_ok = 1'b0;
        end
        if (prof_reg[i].duplex != prof_reg[0].duplex) begin
          set_ok = 1'b0;
        end
        if (i > 0 && prof_reg[i].rate !=
            16'(prof_reg[(i > 0) ? i - 1 : 0].rate << 1)) begin
          set_ok = 1'b0;
        end
      end
    end
  end

  // Channels must all be parked out of the active state
  always_comb begin
    all_primed = 1'b1;
    for (int c = 0; c < N_CH; c++) begin
      if (ch_state[c] == CH_ACTIVE) begin
        all_primed = 1'b0;
      end
    end
  end

  // Command decode
  assign go_req = wr && paddr == CTRL_OFF && pwdata[CTRL_GO_BIT];
  assign stage_req = wr && (paddr == NEXT_OFF ||
    paddr == TAP_DATA_OFF);
  assign go_ok = en_reg && !hop_reg && next_vld_reg &&
    all_primed && seq_reg == SEQ_IDLE && nxt.lvds &&
    nxt.duplex == act_reg.duplex;
  assign go_bad = go_req && !go_ok;
  assign stage_bad = (stage_req && seq_reg == SEQ_SWITCH) ||
    (wr && paddr == NEXT_OFF && pwdata[2:0] >= count_reg);
  assign en_bad = wr && paddr == CTRL_OFF &&
    pwdata[CTRL_EN_BIT] && !en_reg &&
    (!set_ok || pwdata[CTRL_HOP_BIT] || hop_reg);

  // Read mux; unmapped reads return zero with an error
  always_comb begin
    prdata = WORD_RST;
    pslverr = 1'b0;
    if (rd) begin
      case (paddr)
        CTRL_OFF: begin
          prdata = {30'h0, hop_reg, en_reg};
        end
        NEXT_OFF: begin
          prdata = {28'h0, next_vld_reg, next_reg};
        end
        STATUS_OFF: begin
          prdata = {16'h0, link_reg[7:0], 1'b0, act_idx_reg,
            taps_vld_reg, err_reg, stage_busy, switch_busy};
        end
        COUNT_OFF: begin
          prdata = {29'h0, count_reg};
        end
        FIXED_OFF: begin
          prdata = fixed_reg;
        end
        TAP_SEL_OFF: begin
          prdata = {28'h0, tap_sel_reg};
        end
        TAP_DATA_OFF: begin
          prdata = {16'h0, tap_sel_reg[3] ?
            tx_stg_reg[tap_sel_reg[1:0]] :
            rx_stg_reg[tap_sel_reg[1:0]]};
        end
        default: begin
          if (hit_prof) begin
            prdata = prof_reg[prof_idx];
          end else begin
            pslverr = 1'b1;
          end
        end
      endcase
    end else if (psel && !hit_prof && paddr > TAP_DATA_OFF) begin
      pslverr = 1'b1;
    end
  end

  // Profile table, frozen while hot swap mode runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MAX_PROFILES; i++) begin
        prof_reg[i] <= WORD_RST;
      end
      count_reg <= COUNT_RST;
    end else if (wr && !en_reg) begin
      if (hit_prof) begin
        prof_reg[prof_idx] <= pwdata;
      end
      if (paddr == COUNT_OFF) begin
        count_reg <= pwdata[2:0];
      end
    end
  end

  // Invariant settings: locked in hot swap mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_reg <= WORD_RST;
    end else if (wr && paddr == FIXED_OFF && !en_reg) begin
      fixed_reg <= pwdata;
    end
  end

  // Mode bits; hopping and hot swap never both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
      hop_reg <= 1'b0;
    end else if (wr && paddr == CTRL_OFF && seq_reg == SEQ_IDLE) begin
      if (!pwdata[CTRL_EN_BIT]) begin
        en_reg <= 1'b0;
        hop_reg <= pwdata[CTRL_HOP_BIT];
      end else if (!en_bad) begin
        en_reg <= 1'b1;
        hop_reg <= 1'b0;
      end
    end
  end

  // Sticky error; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (go_bad || stage_bad || en_bad) begin
      err_reg <= 1'b1;
    end else if (wr && paddr == CTRL_OFF && pwdata[CTRL_CLR_BIT]) begin
      err_reg <= 1'b0;
    end
  end

  // Next profile staging, no channel state check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_reg <= 3'h0;
      next_vld_reg <= 1'b0;
    end else if (wr && paddr == NEXT_OFF && !stage_bad) begin
      next_reg <= pwdata[2:0];
      next_vld_reg <= 1'b1;
    end else if (seq_reg == SEQ_SWITCH && timer_reg == 16'h0001) begin
      next_vld_reg <= 1'b0;
    end else if (!en_reg) begin
      next_vld_reg <= 1'b0;
    end
  end

  // Tap pointer and staged tap banks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_sel_reg <= 4'h0;
      rx_stg_reg <= '0;
      tx_stg_reg <= '0;
      taps_vld_reg <= 1'b0;
    end else begin
      if (wr && paddr == TAP_SEL_OFF) begin
        tap_sel_reg <= pwdata[3:0];
      end
      if (wr && paddr == TAP_DATA_OFF && !stage_bad) begin
        if (tap_sel_reg[3]) begin
          tx_stg_reg[tap_sel_reg[1:0]] <= pwdata[15:0];
        end else begin
          rx_stg_reg[tap_sel_reg[1:0]] <= pwdata[15:0];
        end
        taps_vld_reg <= 1'b1;
      end else if (seq_reg == SEQ_SWITCH &&
          timer_reg == 16'h0001) begin
        taps_vld_reg <= 1'b0;
      end
    end
  end

  // Sequencer: staging delay, then timed switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SEQ_IDLE;
      timer_reg <= 16'h0000;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          if (go_req && go_ok) begin
            seq_reg <= SEQ_SWITCH;
            timer_reg <= 16'(SWITCH_CYC);
          end else if (stage_req && !stage_bad) begin
            seq_reg <= SEQ_STAGE;
            timer_reg <= 16'(STAGE_CYCLES);
          end
        end
        SEQ_STAGE: begin
          // Extra staging writes restart processing
          if (stage_req && !stage_bad) begin
            timer_reg <= 16'(STAGE_CYCLES);
          end else if (timer_reg == 16'h0001) begin
            seq_reg <= SEQ_IDLE;
            timer_reg <= 16'h0000;
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        SEQ_SWITCH: begin
          if (timer_reg == 16'h0001) begin
            seq_reg <= SEQ_IDLE;
            timer_reg <= 16'h0000;
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        default: begin
          seq_reg <= SEQ_IDLE;
          timer_reg <= 16'h0000;
        end
      endcase
    end
  end

  // Active profile: main on enable, staged one at switch end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= WORD_RST;
      act_idx_reg <= 3'h0;
      link_reg <= 16'h0000;
    end else if (wr && paddr == CTRL_OFF && !en_reg &&
        pwdata[CTRL_EN_BIT] && !en_bad && seq_reg == SEQ_IDLE) begin
      act_reg <= prof_reg[main_idx];
      act_idx_reg <= main_idx;
      link_reg <= prof_reg[main_idx].rate;
    end else if (seq_reg == SEQ_SWITCH && timer_reg == 16'h0001) begin
      act_reg <= nxt;
      act_idx_reg <= next_reg;
    end
  end

  // Taps in use, swapped only at switch end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_act_reg <= '0;
      tx_act_reg <= '0;
    end else if (seq_reg == SEQ_SWITCH && timer_reg == 16'h0001 &&
        taps_vld_reg) begin
      rx_act_reg <= rx_stg_reg;
      tx_act_reg <= tx_stg_reg;
    end
  end

  // Enable pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_s1_reg <= 2'b00;
      tx_s2_reg <= 2'b00;
      rx_s1_reg <= 2'b00;
      rx_s2_reg <= 2'b00;
    end else begin
      tx_s1_reg <= tx_enable_pin;
      tx_s2_reg <= tx_s1_reg;
      rx_s1_reg <= rx_enable_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // Pins pass through except while switching, where they are
  // forced low so no channel is lit on a half-set profile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_reg <= 2'b00;
      rx_out_reg <= 2'b00;
    end else if (seq_reg == SEQ_SWITCH ||
        (go_req && go_ok)) begin
      tx_out_reg <= 2'b00;
      rx_out_reg <= 2'b00;
    end else begin
      tx_out_reg <= tx_s2_reg;
      rx_out_reg <= rx_s2_reg;
    end
  end

  // Output wiring
  assign tx_enable_out = tx_out_reg;
  assign rx_enable_out = rx_out_reg;
  assign active_cfg = act_reg;
  assign active_index = act_idx_reg;
  assign link_rate = link_reg;
  assign fixed_cfg = fixed_reg;
  assign rx_taps = rx_act_reg;
  assign tx_taps = tx_act_reg;
  assign switch_busy = seq_reg == SEQ_SWITCH;
  assign stage_busy = seq_reg == SEQ_STAGE;
  assign hot_swap_mode = en_reg;
  assign hop_mode = hop_reg;
endmodule // dpss_top

// ==== test/dpss_chan_model.sv ====
/*
  Host-side channel model for the hot swap bench: drives channel
  states and the enable pins. Assumes goal and pin requests come
  from the bench on pclk.
*/
module dpss_chan_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] goal,
  input wire logic [3:0] pin_req,
  output logic [dpss_pkg::N_CH-1:0][1:0] ch_state,
  output logic [1:0] tx_pin,
  output logic [1:0] rx_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  import dpss_pkg::*;
  // Channels follow the goal one at a time, a slow host walking them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_state <= '0;
    end else begin
      ch_state <= {ch_state[N_CH-2:0], goal};
    end
  end
  // Pins only change when the bench asks, even mid switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_pin, rx_pin} <= 4'h0;
    end else begin
      {tx_pin, rx_pin} <= pin_req;
    end
  end
endmodule // dpss_chan_model

// ==== test/dpss_chk.sv ====
/*
  Concurrent checks on the hot swap sequencer ports.
  Assumes one pclk domain and the bind at the foot of this file.
*/
module dpss_chk #(
  parameter int SWITCH_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [dpss_pkg::N_CH-1:0][1:0] ch_state,
  input wire logic [1:0] tx_enable_out,
  input wire logic [1:0] rx_enable_out,
  input wire dpss_pkg::dpss_profile_s active_cfg,
  input wire logic [15:0] link_rate,
  input wire dpss_pkg::dpss_fixed_s fixed_cfg,
  input wire logic switch_busy,
  input wire logic hot_swap_mode,
  input wire logic hop_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  import dpss_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] busy_cnt_reg; // Cycles of the running switch
  logic go_w; // Switch command in an access cycle
  logic any_act; // Some channel still active
  assign go_w = psel && penable && pwrite && paddr == CTRL_OFF
    && pwdata[CTRL_GO_BIT];
  // Any channel in the active state
  always_comb begin
    any_act = 1'b0;
    for (int i = 0; i < N_CH; i++) begin
      if (ch_state[i] == CH_ACTIVE) any_act = 1'b1;
    end
  end
  // Busy run length, so long runs need no big repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_reg <= '0;
    else if (switch_busy) busy_cnt_reg <= busy_cnt_reg + 16'h1;
    else busy_cnt_reg <= '0;
  end
  sequence s_swap_start;
    !switch_busy ##1 switch_busy;
  endsequence
  sequence s_swap_end;
    switch_busy ##1 !switch_busy;
  endsequence
  a_busy_len: assert property ($fell(switch_busy) |->
    busy_cnt_reg == 16'(SWITCH_CYC)) else $error("switch length off");
  a_busy_cause: assert property (s_swap_start |->
    $past(go_w) || $past(go_w, 2)) else $error("busy without go");
  a_pins_gated: assert property (switch_busy |->
    tx_enable_out == 2'h0 && rx_enable_out == 2'h0)
    else $error("enable passed during switch");
  a_cfg_moves: assert property ($changed(active_cfg) |->
    $fell(switch_busy) || $changed(hot_swap_mode))
    else $error("profile moved outside switch");
  a_fixed_hold: assert property (switch_busy |=>
    $stable(fixed_cfg) && $stable(link_rate))
    else $error("fixed setting moved in switch");
  a_rate_top: assert property ($rose(hot_swap_mode) |->
    link_rate == active_cfg.rate) else $error("link rate not top");
  a_mode_excl: assert property (!(hot_swap_mode && hop_mode))
    else $error("hop and hot swap both on");
  a_swap_mode: assert property (s_swap_start |->
    hot_swap_mode && !hop_mode) else $error("switch outside mode");
  a_primed_first: assert property (s_swap_start |->
    !$past(any_act)) else $error("switch with active channel");
  a_duplex_keep: assert property (s_swap_end |->
    active_cfg.duplex == $past(active_cfg.duplex) && active_cfg.lvds)
    else $error("duplex or link type changed");
  a_unmapped: assert property (psel && penable && paddr == 8'h1C
    |-> pslverr) else $error("hole not refused");
endmodule // dpss_chk

bind dpss_top dpss_chk #(.SWITCH_CYC(SWITCH_CYC)) i_chk (.pclk,
  .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pslverr,
  .ch_state, .tx_enable_out, .rx_enable_out, .active_cfg, .link_rate,
  .fixed_cfg, .switch_busy, .hot_swap_mode, .hop_mode);

// ==== test/tb_dynamic_profile_switch_sequencer.sv ====
/*
  Self-checking bench for the hot swap sequencer over APB.
  Assumes dpss_chan_model plays the host's channel side.
*/
module tb_dynamic_profile_switch_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import dpss_pkg::*;
  localparam int SW = 20; // Short switch for simulation
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, tapv;
  logic [1:0] goal, tx_pin, rx_pin, tx_out, rx_out, dup;
  logic [3:0] pin_req, sel;
  logic [N_CH-1:0][1:0] ch_state;
  dpss_profile_s act_cfg, prof [MAX_PROFILES];
  dpss_fixed_s fixed_cfg, fixed_w;
  dpss_profile_s bad; // Corrupted profile word for the refusal corner
  logic [2:0] act_idx;
  logic [15:0] link_rate;
  logic [N_TAPS-1:0][15:0] rx_taps, tx_taps;
  logic sw_busy, st_busy, hs_mode, hop;
  int miscompares, n_compared, cnt, n, idx, k;
  logic [1:0] st_tab [4] = '{CH_STANDBY, CH_CALIBRATED, CH_PRIMED,
    CH_ACTIVE};
  dpss_top #(.SWITCH_CYC(SW)) i_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_state(ch_state), .tx_enable_pin(tx_pin),
    .rx_enable_pin(rx_pin), .tx_enable_out(tx_out),
    .rx_enable_out(rx_out), .active_cfg(act_cfg),
    .active_index(act_idx), .link_rate(link_rate),
    .fixed_cfg(fixed_cfg), .rx_taps(rx_taps), .tx_taps(tx_taps),
    .switch_busy(sw_busy), .stage_busy(st_busy),
    .hot_swap_mode(hs_mode), .hop_mode(hop));
  dpss_chan_model i_host (.pclk(pclk), .presetn(presetn), .goal(goal),
    .pin_req(pin_req), .ch_state(ch_state), .tx_pin(tx_pin),
    .rx_pin(rx_pin));
  // Free running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, then an idle edge so strobes never re-assert
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int t;
    t = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  // Wait out staging and switching; pins toggle meanwhile
  task automatic wait_idle;
    int t;
    t = 0;
    cnt = 0;
    while ((sw_busy !== 1'b0 || st_busy !== 1'b0) && t < 1000) begin
      if (sw_busy === 1'b1) begin
        cnt++;
        chk({tx_out, rx_out}, 32'h0);
      end
      pin_req <= 4'($urandom);
      @(posedge pclk);
      t++;
    end
    if (t >= 1000) begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, goal, pin_req} = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(59022));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, STATUS_OFF, 0);
    chk(rd, WORD_RST);
    apb(0, COUNT_OFF, 0);
    chk(rd, 32'(COUNT_RST));
    // Set at the rate ceiling, strict doubling, same duplex
    n = 2 + $urandom_range(4);
    dup = 2'($urandom);
    for (int i = 0; i < n; i++) begin
      prof[i] = {3'h0, dup, 1'b1, 10'($urandom_range(1023, 10)),
        16'((MAX_RATE_KSPS >> (n - 1)) << i)};
      if (i == 0) prof[i].bw = MIN_BW_UNITS; // Narrowest allowed
      apb(1, PROF_BASE_OFF + 8'(4 * i), prof[i]);
    end
    apb(1, COUNT_OFF, n);
    fixed_w = $urandom;
    apb(1, FIXED_OFF, fixed_w);
    // Corner: one broken profile keeps hot swap off
    idx = $urandom_range(n - 1);
    bad = prof[idx];
    case ($urandom_range(3))
      0: bad.bw = MIN_BW_UNITS - 10'h001;
      1: bad.lvds = 1'b0;
      2: bad.duplex = ~dup;
      default: bad.rate = bad.rate + 16'h0001;
    endcase
    apb(1, PROF_BASE_OFF + 8'(4 * idx), bad);
    apb(1, CTRL_OFF, 32'h1);
    chk(hs_mode, 0);
    apb(0, STATUS_OFF, 0);
    chk(rd[2], 1);
    // Restore the good word and clear the refusal flag
    apb(1, PROF_BASE_OFF + 8'(4 * idx), prof[idx]);
    apb(1, CTRL_OFF, 32'h8);
    apb(1, CTRL_OFF, 32'h1);
    chk(hs_mode, 1);
    chk(act_idx, n - 1);
    chk(act_cfg, prof[n - 1]);
    chk(link_rate, prof[n - 1].rate);
    apb(1, FIXED_OFF, ~fixed_w);
    chk(fixed_cfg, fixed_w);
    for (k = 0; k < 4; k++) begin
      // Stage in each channel state
      goal <= st_tab[k];
      repeat (6) @(posedge pclk);
      idx = $urandom_range(n - 1);
      sel = {1'($urandom), 1'b0, 2'($urandom)};
      tapv = 32'($urandom_range(16'hFFFF));
      apb(1, NEXT_OFF, idx);
      apb(1, TAP_SEL_OFF, sel);
      apb(1, TAP_DATA_OFF, tapv);
      chk(st_busy, 1);
      wait_idle;
      // Go refused while a channel is active
      goal <= CH_ACTIVE;
      repeat (6) @(posedge pclk);
      apb(1, CTRL_OFF, 32'h5);
      chk(sw_busy, 0);
      apb(0, STATUS_OFF, 0);
      chk(rd[2], 1);
      apb(1, CTRL_OFF, 32'h9);
      goal <= CH_PRIMED;
      repeat (6) @(posedge pclk);
      apb(1, CTRL_OFF, 32'h5);
      wait_idle;
      chk(cnt, SW);
      chk(act_idx, idx);
      chk(act_cfg, prof[idx]);
      chk(link_rate, prof[n - 1].rate);
      // Link to sample ratio stays a power of two
      chk(link_rate, 16'(prof[idx].rate << (n - 1 - idx)));
      chk(fixed_cfg, fixed_w);
      chk(sel[3] ? tx_taps[sel[1:0]] : rx_taps[sel[1:0]], tapv);
      // Pins pass again once the switch is over
      pin_req <= 4'($urandom);
      repeat (5) @(posedge pclk);
      chk({tx_out, rx_out}, 32'(pin_req));
    end
    // Staging was consumed: a second go is refused
    apb(1, CTRL_OFF, 32'h5);
    chk(sw_busy, 0);
    apb(0, NEXT_OFF, 0);
    chk(rd[3], 0);
    apb(0, 8'h1C, 0);
    chk(er, 1);
    // Hopping locks out hot swap; flag cleared first so it can trip
    apb(1, CTRL_OFF, 32'hA);
    chk({hs_mode, hop}, 2'b01);
    apb(0, STATUS_OFF, 0);
    chk(rd[2], 0);
    apb(1, CTRL_OFF, 32'h3);
    chk(hs_mode, 0);
    apb(0, STATUS_OFF, 0);
    chk(rd[2], 1);
    tally_and_finish;
  end
endmodule // tb_dynamic_profile_switch_sequencer
